// ==== rtl/slm_pkg.sv ====
// Purpose: shared constants and carriers for the lane sample mapper
// Assumes: 9-bit samples, up to four channels, up to eight lanes
// Notes:   lane words are msb-first, nibble 0 in bits [63:60]
package slm_pkg;
  localparam int SAMP_W      = 9;
  localparam int NUM_CH      = 4;
  localparam int SAMP_PER_CH = 20;
  localparam int NUM_LANES   = 8;
  localparam int LANE_W      = 64;
  localparam int FIFO_DEPTH  = 16;

  // format 10: four 10-bit words per lane frame, one zero pad bit
  localparam int F10_WORD_W = 10;
  localparam int F10_WORDS  = 4;
  localparam int F10_PAD_W  = 1;
  // format 11: five 12-bit words, three zero pad bits, one trailing nibble
  localparam int F11_WORD_W = 12;
  localparam int F11_WORDS  = 5;
  localparam int F11_PAD_W  = 3;
  localparam int F11_STRIDE = 4;
  localparam int NIB_W      = 4;

  localparam logic [3:0] FMT_TEN    = 4'ha;
  localparam logic [3:0] FMT_ELEVEN = 4'hb;

  localparam logic [1:0] PART_SINGLE = 2'h0;
  localparam logic [1:0] PART_DUAL   = 2'h1;
  localparam logic [1:0] PART_QUAD   = 2'h2;

  localparam logic [7:0] EN_F10_SINGLE = 8'h03;
  localparam logic [7:0] EN_F10_DUAL   = 8'h0f;
  localparam logic [7:0] EN_F10_QUAD   = 8'hff;
  localparam logic [7:0] EN_F11_SINGLE = 8'h0f;
  localparam logic [7:0] EN_F11_DUAL   = 8'hff;
  localparam logic [7:0] EN_NONE       = 8'h00;

  typedef logic [SAMP_W-1:0] slm_sample_type;
  typedef slm_sample_type [NUM_CH-1:0][SAMP_PER_CH-1:0] slm_block_type;
  typedef logic [NUM_LANES-1:0][LANE_W-1:0] slm_lanes_type;

  typedef struct packed {
    slm_lanes_type         data;
    logic [NUM_LANES-1:0]  en;
    logic                  valid;
    logic                  err;
    logic [3:0]            fmt;
    logic [1:0]            part;
  } slm_out_type;
endpackage

// ==== rtl/slm_lane_mapper.sv ====
// Purpose: map converter sample blocks onto serial lane frames, formats 10 and 11
// Assumes: config inputs come from logic on clk_sys_in and change only between frames
// Notes:   one sample block per frame, buffered in a 16-word fifo
// Operation
// - format 10 sends 9-bit samples on eight, four or two lanes for quad, dual or single parts.
// - format 10 lane frames hold four sample-plus-zero words, even samples on the first lane.
// - format 10 puts channel a on lanes 0-1, b on 2-3, c on 4-5 and d on 6-7.
// - format 11 exists only on dual and single parts, using eight or four lanes.
// - format 11 lane n carries samples n, n+4, n+8, n+12, n+16 padded to 12 bits plus a nibble.
// - format 11 puts channel a on lanes 0-3 and channel b on lanes 4-7.
`timescale 1ns/1ps

module slm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  // depth must be a power of two so pointers wrap for free
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
    logic          ready;
  } slm_fifo_st_type;

  slm_fifo_st_type  st_r;
  slm_fifo_st_type  st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign push          = in_valid_in && st_r.ready;
  assign pop           = out_valid_out && out_ready_in;
  assign in_ready_out  = st_r.ready;
  assign out_valid_out = (st_r.cnt != '0);
  assign out_data_out  = mem[st_r.rd];

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (pop)
    begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
    st_nxt.cnt   = st_r.cnt + CW'(push) - CW'(pop);
    st_nxt.ready = (st_nxt.cnt != FULL_CNT);
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_r <= '{wr: '0, rd: '0, cnt: '0, ready: 1'b1};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (push)
    begin
      mem[st_r.wr] <= in_data_in;
    end
  end
endmodule

module slm_lane_mapper #(
  parameter int DEPTH = slm_pkg::FIFO_DEPTH
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 resetn_in,
  input  wire logic [3:0]           link_format_select_in,
  input  wire logic [1:0]           part_type_in,
  input  wire logic                 samp_valid_in,
  input  wire slm_pkg::slm_block_type samp_data_in,
  output logic                      samp_ready_out,
  output slm_pkg::slm_lanes_type    lane_data_out,
  output logic [slm_pkg::NUM_LANES-1:0] lane_en_out,
  output logic                      lane_valid_out,
  input  wire logic                 lane_ready_in,
  output logic                      fmt_err_out
);
  localparam int BLK_W = $bits(slm_pkg::slm_block_type);
  localparam int LW    = slm_pkg::LANE_W;

  slm_pkg::slm_out_type   st_r;
  slm_pkg::slm_out_type   st_nxt;
  slm_pkg::slm_block_type blk;
  slm_pkg::slm_lanes_type f10;
  slm_pkg::slm_lanes_type f11;
  logic                   blk_valid;
  logic                   take;
  logic [7:0]             en_sel;
  logic                   cfg_bad;

  // back-pressure from the lanes stalls the fifo, which stalls the source
  assign take = blk_valid && (!st_r.valid || lane_ready_in);

  slm_fifo #(
    .WIDTH (BLK_W),
    .DEPTH (DEPTH)
  ) i_slm_fifo (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (samp_valid_in),
    .in_data_in    (samp_data_in),
    .in_ready_out  (samp_ready_out),
    .out_valid_out (blk_valid),
    .out_data_out  (blk),
    .out_ready_in  (take)
  );

  for (genvar l = 0; l < slm_pkg::NUM_LANES; l++)
  begin : g_lane
    localparam int CH10 = l / 2;
    localparam int PAR  = l % 2;
    localparam int CH11 = l / slm_pkg::F11_STRIDE;
    localparam int N11  = l % slm_pkg::F11_STRIDE;
    for (genvar k = 0; k < slm_pkg::F10_WORDS; k++)
    begin : g_w10
      // first lane of a channel even samples, second lane odd
      assign f10[l][LW-1-k*slm_pkg::F10_WORD_W -: slm_pkg::F10_WORD_W] =
        {blk[CH10][2*k+PAR], {slm_pkg::F10_PAD_W{1'b0}}};
    end
    assign f10[l][LW-1-slm_pkg::F10_WORDS*slm_pkg::F10_WORD_W:0] = '0;
    for (genvar k = 0; k < slm_pkg::F11_WORDS; k++)
    begin : g_w11
      // lane n takes every fourth sample from n
      assign f11[l][LW-1-k*slm_pkg::F11_WORD_W -: slm_pkg::F11_WORD_W] =
        {blk[CH11][N11+slm_pkg::F11_STRIDE*k], {slm_pkg::F11_PAD_W{1'b0}}};
    end
    assign f11[l][slm_pkg::NIB_W-1:0] = '0;
  end

  always_comb
  begin
    en_sel  = slm_pkg::EN_NONE;
    cfg_bad = 1'b0;
    case (link_format_select_in)
      slm_pkg::FMT_TEN:
      begin
        case (part_type_in)
          slm_pkg::PART_QUAD:   en_sel = slm_pkg::EN_F10_QUAD;
          slm_pkg::PART_DUAL:   en_sel = slm_pkg::EN_F10_DUAL;
          slm_pkg::PART_SINGLE: en_sel = slm_pkg::EN_F10_SINGLE;
          default:              cfg_bad = 1'b1;
        endcase
      end
      slm_pkg::FMT_ELEVEN:
      begin
        case (part_type_in) // quad parts have no format 11
          slm_pkg::PART_DUAL:   en_sel = slm_pkg::EN_F11_DUAL;
          slm_pkg::PART_SINGLE: en_sel = slm_pkg::EN_F11_SINGLE;
          default:              cfg_bad = 1'b1;
        endcase
      end
      default:
      begin
        cfg_bad = 1'b1;
      end
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    if (st_r.valid && lane_ready_in)
    begin
      st_nxt.valid = 1'b0;
    end
    if (take)
    begin
      // an illegal setting drops the frame rather than putting garbage on the lanes
      st_nxt.err   = cfg_bad;
      st_nxt.valid = !cfg_bad;
      st_nxt.en    = en_sel;
      st_nxt.fmt   = link_format_select_in;
      st_nxt.part  = part_type_in;
      for (int l = 0; l < slm_pkg::NUM_LANES; l++)
      begin
        if (!en_sel[l])
        begin
          st_nxt.data[l] = '0;
        end
        else if (link_format_select_in == slm_pkg::FMT_TEN)
        begin
          st_nxt.data[l] = f10[l];
        end
        else
        begin
          st_nxt.data[l] = f11[l];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign lane_data_out  = st_r.data;
  assign lane_en_out    = st_r.en;
  assign lane_valid_out = st_r.valid;
  assign fmt_err_out    = st_r.err;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  lane_count_a: assert property (
    lane_valid_out && st_r.fmt == slm_pkg::FMT_TEN |->
      lane_en_out == (st_r.part == slm_pkg::PART_QUAD ? 8'hff :
                      st_r.part == slm_pkg::PART_DUAL ? 8'h0f : 8'h03))
    else $error("format 10 lane count wrong");
  even_odd_a: assert property (
    take && link_format_select_in == slm_pkg::FMT_TEN && !cfg_bad |=>
      lane_data_out[1][63:54] == {$past(blk[0][1]), 1'b0} &&
      lane_data_out[0][33:24] == {$past(blk[0][6]), 1'b0})
    else $error("format 10 sample order wrong");
  chan_lanes_a: assert property (
    take && link_format_select_in == slm_pkg::FMT_TEN &&
      part_type_in == slm_pkg::PART_QUAD |=>
      lane_data_out[2][63:55] == $past(blk[1][0]) &&
      lane_data_out[7][33:25] == $past(blk[3][7]))
    else $error("format 10 channel lanes wrong");
  quad_reject_a: assert property (
    take && link_format_select_in == slm_pkg::FMT_ELEVEN &&
      part_type_in == slm_pkg::PART_QUAD |=> fmt_err_out && !lane_valid_out)
    else $error("format 11 accepted on quad part");
  stride_four_a: assert property (
    take && link_format_select_in == slm_pkg::FMT_ELEVEN && !cfg_bad |=>
      lane_data_out[1][51:43] == $past(blk[0][5]) &&
      lane_data_out[3][15:7] == $past(blk[0][19]) &&
      lane_data_out[3][6:0] == 7'h00)
    else $error("format 11 sample stride wrong");
  chan_b_a: assert property (
    take && link_format_select_in == slm_pkg::FMT_ELEVEN &&
      part_type_in == slm_pkg::PART_DUAL |=>
      lane_data_out[4][63:55] == $past(blk[1][0]) && lane_en_out == 8'hff)
    else $error("format 11 channel b lanes wrong");
  nibble_order_a: assert property (
    take && !cfg_bad |=> lane_data_out[0][63:60] == $past(blk[0][0][8:5]))
    else $error("nibble 0 not top of octet 0");
  hold_stall_a: assert property (
    lane_valid_out && !lane_ready_in |=> lane_valid_out && $stable(lane_data_out))
    else $error("lane frame changed under stall");

  f10_quad_c: cover property (lane_valid_out && st_r.fmt == slm_pkg::FMT_TEN &&
    st_r.part == slm_pkg::PART_QUAD);
  f11_dual_c: cover property (lane_valid_out && st_r.fmt == slm_pkg::FMT_ELEVEN &&
    st_r.part == slm_pkg::PART_DUAL);
  fifo_full_c: cover property (!samp_ready_out);
  err_c: cover property (fmt_err_out);
endmodule

// ==== test/slm_rx_model.sv ====
// Purpose: receiver model at the lane side of the mapper
// Assumes: frames are taken at a rising edge with valid and ready high
// Notes:   stall comes from the bench and only delays acceptance
`timescale 1ns/1ps

module slm_rx_model (
  input  wire logic                   clk_sys_in,
  input  wire logic                   resetn_in,
  input  wire logic                   stall_in,
  input  wire logic                   lane_valid_in,
  input  wire slm_pkg::slm_lanes_type lane_data_in,
  input  wire logic [7:0]             lane_en_in,
  output logic                        lane_ready_out,
  output slm_pkg::slm_lanes_type      last_data_out,
  output logic [7:0]                  last_en_out,
  output int                          count_out
);
  assign lane_ready_out = !stall_in;

  // keeps the whole frame; words are read back msb-first, nibble 0 on top
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      count_out     <= 0;
      last_data_out <= '0;
      last_en_out   <= '0;
    end
    else if (lane_valid_in && lane_ready_out)
    begin
      count_out     <= count_out + 1;
      last_data_out <= lane_data_in;
      last_en_out   <= lane_en_in;
    end
  end
endmodule

// ==== test/test_slm_lane_mapper.sv ====
// Purpose: self-checking bench for the lane sample mapper
// Assumes: config held steady while a frame is in flight
// Notes:   expectations are built from the lane layout tables
`timescale 1ns/1ps

module test_slm_lane_mapper;
  logic                   clk_sys_in = 0;
  logic                   resetn_in = 0;
  logic                   valid = 0;
  logic                   stall = 0;
  logic [3:0]             fmt = 4'ha;
  logic [1:0]             part = 2'h2;
  slm_pkg::slm_block_type blk = '0;
  slm_pkg::slm_lanes_type ldata, rdata;
  logic                   rdy, lvalid, lready, err;
  logic [7:0]             len, ren;
  int                     rcount;
  int                     num_errors = 0;
  int                     comparisons = 0;

  slm_lane_mapper #(.DEPTH(16)) i_slm_lane_mapper (.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .link_format_select_in(fmt), .part_type_in(part),
    .samp_valid_in(valid), .samp_data_in(blk), .samp_ready_out(rdy),
    .lane_data_out(ldata), .lane_en_out(len), .lane_valid_out(lvalid),
    .lane_ready_in(lready), .fmt_err_out(err));
  slm_rx_model i_slm_rx_model (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .stall_in(stall), .lane_valid_in(lvalid), .lane_data_in(ldata),
    .lane_en_in(len), .lane_ready_out(lready), .last_data_out(rdata),
    .last_en_out(ren), .count_out(rcount));

  initial
  begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  function automatic slm_pkg::slm_block_type mk(int sd);
    slm_pkg::slm_block_type b;
    for (int c = 0; c < 4; c++)
      for (int s = 0; s < 20; s++)
        b[c][s] = 9'(sd * 7 + c * 41 + s * 19 + 3);
    return b;
  endfunction

  function automatic logic [7:0] exp_en(logic [3:0] f, logic [1:0] p);
    if (f == slm_pkg::FMT_TEN && p == slm_pkg::PART_SINGLE) return slm_pkg::EN_F10_SINGLE;
    if (f == slm_pkg::FMT_TEN && p == slm_pkg::PART_DUAL) return slm_pkg::EN_F10_DUAL;
    if (f == slm_pkg::FMT_TEN && p == slm_pkg::PART_QUAD) return slm_pkg::EN_F10_QUAD;
    if (f == slm_pkg::FMT_ELEVEN && p == slm_pkg::PART_SINGLE) return slm_pkg::EN_F11_SINGLE;
    if (f == slm_pkg::FMT_ELEVEN && p == slm_pkg::PART_DUAL) return slm_pkg::EN_F11_DUAL;
    return slm_pkg::EN_NONE;
  endfunction

  function automatic slm_pkg::slm_lanes_type exp_lanes(logic [3:0] f, logic [1:0] p,
                                                       slm_pkg::slm_block_type b);
    slm_pkg::slm_lanes_type r;
    logic [7:0]             e;
    r = '0;
    e = exp_en(f, p);
    for (int l = 0; l < 8; l++)
      if (e[l] && f == slm_pkg::FMT_TEN)
        for (int k = 0; k < 4; k++)
          r[l][63-10*k -: 10] = {b[l/2][2*k+l%2], 1'b0};
      else if (e[l])
        for (int k = 0; k < 5; k++)
          r[l][63-12*k -: 12] = {b[l/4][l%4+4*k], 3'h0};
    return r;
  endfunction

  task automatic chk(logic [511:0] seen, logic [511:0] exp, string what);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_rx(int n);
    int i;
    i = 0;
    while (rcount < n && i < 200)
    begin
      @(negedge clk_sys_in);
      i++;
    end
    if (rcount < n)
    begin
      chk(0, 1, "timeout");
      report_and_stop();
    end
  endtask

  // called at a falling edge; holds the block until it is taken
  task automatic push(slm_pkg::slm_block_type b);
    int i;
    i = 0;
    blk = b;
    valid = 1;
    while (rdy !== 1'b1 && i < 100)
    begin
      @(negedge clk_sys_in);
      i++;
    end
    if (rdy !== 1'b1)
    begin
      chk(0, 1, "input never ready");
      report_and_stop();
    end
    @(negedge clk_sys_in);
    valid = 0;
  endtask

  task automatic frame(logic [3:0] f, logic [1:0] p, int sd);
    int base;
    base = rcount;
    fmt = f;
    part = p;
    push(mk(sd));
    wait_rx(base + 1);
    chk(rdata, exp_lanes(f, p, mk(sd)), "lane data");
    chk(ren, exp_en(f, p), "lane enables");
  endtask

  task automatic test_formats();
    frame(slm_pkg::FMT_TEN, slm_pkg::PART_QUAD, 1);
    frame(slm_pkg::FMT_TEN, slm_pkg::PART_DUAL, 2);
    frame(slm_pkg::FMT_TEN, slm_pkg::PART_SINGLE, 3);
    frame(slm_pkg::FMT_ELEVEN, slm_pkg::PART_DUAL, 4);
    frame(slm_pkg::FMT_ELEVEN, slm_pkg::PART_SINGLE, 5);
    $display("test_formats done");
  endtask

  // a setting with no lane layout must drop its block and raise the error flag
  task automatic drop(logic [3:0] f, logic [1:0] p, int sd);
    int base;
    base = rcount;
    fmt = f;
    part = p;
    push(mk(sd));
    repeat (4) @(negedge clk_sys_in);
    chk(err, 1, "error flag");
    chk(rcount, base, "dropped frame sent");
  endtask

  // a legal frame between drops so each drop must raise the flag afresh
  task automatic test_illegal();
    drop(slm_pkg::FMT_ELEVEN, slm_pkg::PART_QUAD, 6);
    frame(slm_pkg::FMT_TEN, slm_pkg::PART_QUAD, 7);
    chk(err, 0, "error flag stuck");
    drop(4'h0, slm_pkg::PART_DUAL, 8);
    frame(slm_pkg::FMT_ELEVEN, slm_pkg::PART_SINGLE, 11);
    chk(err, 0, "error flag stuck");
    drop(slm_pkg::FMT_TEN, 2'h3, 12);
    frame(slm_pkg::FMT_TEN, slm_pkg::PART_DUAL, 13);
    chk(err, 0, "error flag stuck");
    $display("test_illegal done");
  endtask

  task automatic test_fill();
    int base;
    int k;
    base = rcount;
    k = 0;
    fmt = slm_pkg::FMT_ELEVEN;
    part = slm_pkg::PART_DUAL;
    stall = 1;
    valid = 1;
    while (rdy === 1'b1 && k < 40)
    begin
      blk = mk(10 + k);
      @(negedge clk_sys_in);
      k++;
    end
    valid = 0;
    // fifo words plus the held output frame
    chk(k, slm_pkg::FIFO_DEPTH + 1, "buffer depth wrong");
    stall = 0;
    wait_rx(base + k);
    chk(rdata, exp_lanes(fmt, part, mk(9 + k)), "last frame after drain");
    $display("test_fill done");
  endtask

  initial
  begin
    repeat (5) @(negedge clk_sys_in);
    resetn_in = 1;
    @(negedge clk_sys_in);
    test_formats();
    test_illegal();
    test_fill();
    report_and_stop();
  end
endmodule
